//--- trig_sel_pkg.sv
// Purpose: constants for the timer trigger source selector
// Assumes: 32-bit AHB-Lite register access, word aligned
// Notes:   field layout is shared by both selector registers
package trig_sel_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  BREAK_SEL_OFFSET = 8'h28;
  localparam logic [7:0]  TRIG_SEL_OFFSET  = 8'h2C;
  localparam logic [31:0] BREAK_SEL_RESET  = 32'h39393939;
  localparam logic [31:0] TRIG_SEL_RESET   = 32'h15151515;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int          WRITE_LOCK_BIT = 31;
  localparam int          SEL_WIDTH      = 7;
  localparam int          OUT_COUNT      = 4;
  localparam int          FIELD_STRIDE   = 8;
  // lock bit plus four select fields; bits 23, 15 and 7 are reserved
  localparam logic [31:0] WRITABLE_MASK  = 32'hFF7F7F7F;

  // ----------------------------------------------------------------------
  // AHB encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ     = 2'h3;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam logic [1:0]  HRESP_OKAY     = 2'h0;

endpackage : trig_sel_pkg

//--- trig_source_mux.sv
// Purpose: one registered source multiplexer driven by a select field
// Assumes: source vector width is at most 128 (seven-bit index)
// Notes:   index beyond the source vector gives a low output
`timescale 1ns/1ps
`default_nettype none

module trig_source_mux #(
  parameter int SRC_COUNT = 128
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // selection
  input  wire logic [6:0]           sel,
  input  wire logic [SRC_COUNT-1:0] sources,
  // routed trigger
  output var  logic                 routed_ff
);

  initial begin
    if (SRC_COUNT < 1 || SRC_COUNT > 128) begin
      $error("trig_source_mux: SRC_COUNT must be 1..128");
    end
  end

  logic nxt_routed;

  always_comb begin
    nxt_routed = 1'b0;
    if (32'(sel) < SRC_COUNT) begin
      nxt_routed = sources[sel];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      routed_ff <= 1'b0;
    end else begin
      routed_ff <= nxt_routed;
    end
  end

endmodule : trig_source_mux

`default_nettype wire

//--- timer_trigger_source_mux.sv
// Purpose: lockable trigger source selectors for two timers' inputs
// Assumes: single AHB-Lite slave, word transfers only, zero wait states
// Notes:   outputs lag a select change by one clock
`timescale 1ns/1ps
`default_nettype none

// Contract
// - bit 31 of each selector is a lock that software sets and only reset clears.
// - a write to a locked selector is ignored entirely, otherwise it updates the fields.
// - break selector bits 30:24 choose the source of break output 3.
// - break selector bits 22:16 choose the source of break output 2.
// - break selector bits 14:8 choose the source of break output 1.
// - break selector bits 6:0 choose the source of break output 0.
// - trigger selector fields at the same positions choose trigger outputs 3..0.
// - the break selector is at offset 0x28 and resets to 0x39393939.
// - the trigger selector is at offset 0x2C and resets to 0x15151515.
module timer_trigger_source_mux #(
  parameter int SRC_COUNT = 128
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output var  logic [31:0]          hrdata,
  output var  logic                 hreadyout,
  output var  logic [1:0]           hresp,
  // trigger sources
  input  wire logic [SRC_COUNT-1:0] trigger_sources,
  // routed outputs
  output var  logic [3:0]           break_input,
  output var  logic [3:0]           internal_trigger_input
);

  initial begin
    if (SRC_COUNT < 1 || SRC_COUNT > 128) begin
      $error("timer_trigger_source_mux: SRC_COUNT must be 1..128");
    end
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [6:0] field_of(input logic [31:0] r,
                                          input int idx);
    field_of = r[idx*trig_sel_pkg::FIELD_STRIDE +: trig_sel_pkg::SEL_WIDTH];
  endfunction : field_of

  // select value that names an existing source
  function automatic logic in_range(input logic [6:0] s);
    in_range = 32'(s) < SRC_COUNT;
  endfunction : in_range

  // lock stays once set; locked register keeps every field
  function automatic logic [31:0] apply_write(input logic [31:0] cur,
                                              input logic [31:0] wd);
    logic [31:0] m;
    m = trig_sel_pkg::WRITABLE_MASK;
    if (cur[trig_sel_pkg::WRITE_LOCK_BIT]) begin
      apply_write = cur;
    end else begin
      apply_write = (cur & ~m) | (wd & m);
    end
  endfunction : apply_write

  // ----------------------------------------------------------------------
  // bus address phase capture
  // ----------------------------------------------------------------------
  logic       wr_pend_ff, nxt_wr_pend;
  logic [7:0] wr_addr_ff, nxt_wr_addr;
  logic       access;

  // narrower sizes are outside the contract; treated as a word
  assign access = hsel && hready && (htrans == trig_sel_pkg::HTRANS_NONSEQ
                  || htrans == trig_sel_pkg::HTRANS_SEQ);

  always_comb begin
    nxt_wr_pend = access && hwrite;
    nxt_wr_addr = access ? haddr : wr_addr_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
    end
  end

  // ----------------------------------------------------------------------
  // selector registers
  // ----------------------------------------------------------------------
  logic [31:0] break_sel_ff, nxt_break_sel;
  logic [31:0] trig_sel_ff,  nxt_trig_sel;

  always_comb begin
    nxt_break_sel = break_sel_ff;
    nxt_trig_sel  = trig_sel_ff;
    if (wr_pend_ff) begin
      if (wr_addr_ff[7:2] == trig_sel_pkg::BREAK_SEL_OFFSET[7:2]) begin
        nxt_break_sel = apply_write(break_sel_ff, hwdata);
      end
      if (wr_addr_ff[7:2] == trig_sel_pkg::TRIG_SEL_OFFSET[7:2]) begin
        nxt_trig_sel = apply_write(trig_sel_ff, hwdata);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      break_sel_ff <= trig_sel_pkg::BREAK_SEL_RESET;
      trig_sel_ff  <= trig_sel_pkg::TRIG_SEL_RESET;
    end else begin
      break_sel_ff <= nxt_break_sel;
      trig_sel_ff  <= nxt_trig_sel;
    end
  end

  // ----------------------------------------------------------------------
  // read data and response
  // ----------------------------------------------------------------------
  logic [31:0] rdata_ff, nxt_rdata;

  // read data registered at the address phase, so hrdata is a flop
  always_comb begin
    nxt_rdata = rdata_ff;
    if (access && !hwrite) begin
      unique case (haddr[7:2])
        trig_sel_pkg::BREAK_SEL_OFFSET[7:2]: nxt_rdata = break_sel_ff;
        trig_sel_pkg::TRIG_SEL_OFFSET[7:2]:  nxt_rdata = trig_sel_ff;
        default:                              nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign hrdata = rdata_ff;

  // zero wait states and always OKAY: constant flops
  logic       ready_ff, nxt_ready;
  logic [1:0] resp_ff,  nxt_resp;

  always_comb begin
    nxt_ready = 1'b1;
    nxt_resp  = trig_sel_pkg::HRESP_OKAY;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_ff <= 1'b1;
      resp_ff  <= trig_sel_pkg::HRESP_OKAY;
    end else begin
      ready_ff <= nxt_ready;
      resp_ff  <= nxt_resp;
    end
  end

  assign hreadyout = ready_ff;
  assign hresp     = resp_ff;

  // ----------------------------------------------------------------------
  // source multiplexers
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < trig_sel_pkg::OUT_COUNT; i++) begin : g_out
    trig_source_mux #(.SRC_COUNT(SRC_COUNT)) u_break (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .sel       (field_of(break_sel_ff, i)),
      .sources   (trigger_sources),
      .routed_ff (break_input[i])
    );
    trig_source_mux #(.SRC_COUNT(SRC_COUNT)) u_trig (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .sel       (field_of(trig_sel_ff, i)),
      .sources   (trigger_sources),
      .routed_ff (internal_trigger_input[i])
    );
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // routing checks skip the releasing edge: the output flops still
  // see reset there, hence the sampled hresetn in their antecedents
  lock_sticky_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    break_sel_ff[31] |=> break_sel_ff[31])
    else $error("break lock cleared without reset");

  lock_sticky_trig_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trig_sel_ff[31] |=> trig_sel_ff[31])
    else $error("trigger lock cleared without reset");

  locked_frozen_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    break_sel_ff[31] |=> $stable(break_sel_ff))
    else $error("locked break selector changed");

  locked_frozen_trig_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trig_sel_ff[31] |=> $stable(trig_sel_ff))
    else $error("locked trigger selector changed");

  unlocked_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && !trig_sel_ff[31]
    && wr_addr_ff[7:2] == trig_sel_pkg::TRIG_SEL_OFFSET[7:2]
    |=> trig_sel_ff[30:24] == $past(hwdata[30:24]))
    else $error("unlocked trigger write lost");

  unlocked_break_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && !break_sel_ff[31]
    && wr_addr_ff[7:2] == trig_sel_pkg::BREAK_SEL_OFFSET[7:2]
    |=> break_sel_ff[6:0] == $past(hwdata[6:0]))
    else $error("unlocked break write lost");

  reserved_kept_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    break_sel_ff[23] == 1'b0 && break_sel_ff[15] == 1'b0
    && break_sel_ff[7] == 1'b0)
    else $error("reserved break bit changed");

  reserved_trig_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trig_sel_ff[23] == 1'b0 && trig_sel_ff[15] == 1'b0
    && trig_sel_ff[7] == 1'b0)
    else $error("reserved trigger bit changed");

  break_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn && in_range(break_sel_ff[30:24]) && $stable(break_sel_ff)
    |=> break_input[3] == $past(trigger_sources[break_sel_ff[30:24]]))
    else $error("break output 3 misrouted");

  break2_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn && in_range(break_sel_ff[22:16])
    |=> break_input[2] == $past(trigger_sources[break_sel_ff[22:16]]))
    else $error("break output 2 misrouted");

  break1_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn && in_range(break_sel_ff[14:8])
    |=> break_input[1] == $past(trigger_sources[break_sel_ff[14:8]]))
    else $error("break output 1 misrouted");

  break0_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn && in_range(break_sel_ff[6:0])
    |=> break_input[0] == $past(trigger_sources[break_sel_ff[6:0]]))
    else $error("break output 0 misrouted");

  trig0_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn && in_range(trig_sel_ff[6:0])
    |=> internal_trigger_input[0]
        == $past(trigger_sources[trig_sel_ff[6:0]]))
    else $error("trigger output 0 misrouted");

  trig_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn && in_range(trig_sel_ff[14:8])
    |=> internal_trigger_input[1]
        == $past(trigger_sources[trig_sel_ff[14:8]]))
    else $error("trigger output 1 misrouted");

  trig2_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn && in_range(trig_sel_ff[22:16])
    |=> internal_trigger_input[2]
        == $past(trigger_sources[trig_sel_ff[22:16]]))
    else $error("trigger output 2 misrouted");

  trig3_route_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn && in_range(trig_sel_ff[30:24])
    |=> internal_trigger_input[3]
        == $past(trigger_sources[trig_sel_ff[30:24]]))
    else $error("trigger output 3 misrouted");

  read_back_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    access && !hwrite && haddr[7:2] == trig_sel_pkg::BREAK_SEL_OFFSET[7:2]
    |=> hrdata == $past(break_sel_ff))
    else $error("break selector read mismatch");

  read_back_trig_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    access && !hwrite && haddr[7:2] == trig_sel_pkg::TRIG_SEL_OFFSET[7:2]
    |=> hrdata == $past(trig_sel_ff))
    else $error("trigger selector read mismatch");

  lock_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
    !break_sel_ff[31] ##1 break_sel_ff[31]);
  trig_lock_c: cover property (@(posedge hclk) disable iff (!hresetn)
    !trig_sel_ff[31] ##1 trig_sel_ff[31]);
  locked_write_c: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && trig_sel_ff[31]);
  sel_change_c: cover property (@(posedge hclk) disable iff (!hresetn)
    !$stable(trig_sel_ff[6:0]));
  route_oob_c: cover property (@(posedge hclk) disable iff (!hresetn)
    !in_range(break_sel_ff[22:16]));

endmodule : timer_trigger_source_mux

`default_nettype wire

//--- trig_far_side.sv
// Purpose: far side model, the trigger sources that feed the selector
// Assumes: sources are plain levels, sampled on hclk
// Notes:   a fresh pattern every cycle so a stale index soon mismatches
`timescale 1ns/1ps
`default_nettype none
module trig_far_side #(
  parameter int SRC_COUNT = 100
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // trigger sources
  output var  logic [SRC_COUNT-1:0] sources
);
  integer       seed = 65;
  logic [127:0] pat;

  // sources stay low while the selector is in reset
  always @(posedge hclk) begin
    pat = {$random(seed), $random(seed), $random(seed), $random(seed)};
    sources <= hresetn ? pat[SRC_COUNT-1:0] : '0;
  end
endmodule : trig_far_side
`default_nettype wire

//--- testbench.sv
// Purpose: random and corner tests of the lockable trigger selector
// Assumes: single ahb-lite master, hready tied to hreadyout
// Notes:   100 sources, so select values 100..127 must route low
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int          SRC = 100;
  localparam logic [7:0]  BRK = trig_sel_pkg::BREAK_SEL_OFFSET;
  localparam logic [7:0]  TRG = trig_sel_pkg::TRIG_SEL_OFFSET;
  localparam logic [31:0] RB  = trig_sel_pkg::BREAK_SEL_RESET;
  localparam logic [31:0] RT  = trig_sel_pkg::TRIG_SEL_RESET;
  logic           hclk = 1'b0;
  logic           hresetn = 1'b0;
  logic           hsel = 1'b0;
  logic [7:0]     haddr = 8'h00;
  logic [1:0]     htrans = 2'h0;
  logic           hwrite = 1'b0;
  logic [2:0]     hsize = trig_sel_pkg::HSIZE_WORD;
  logic [31:0]    hwdata = 32'h0;
  logic [31:0]    hrdata;
  logic           hreadyout;
  logic [1:0]     hresp;
  logic [SRC-1:0] srcs;
  logic [3:0]     brk, trg, snap_b, snap_t;
  logic [31:0]    m_brk, m_trg, rd, d;
  logic [7:0]     a;
  logic           mon_on = 1'b0;
  integer         seed = 65;
  integer         n_errors = 0;
  integer         n_checks = 0;

  always #4 hclk = ~hclk;

  timer_trigger_source_mux #(.SRC_COUNT(SRC)) timer_trigger_source_mux_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .trigger_sources(srcs), .break_input(brk), .internal_trigger_input(trg));

  trig_far_side #(.SRC_COUNT(SRC)) trig_far_side_inst (
    .hclk(hclk), .hresetn(hresetn), .sources(srcs));

  // ----------------------------------------------------------------------
  // expectation and comparison
  // ----------------------------------------------------------------------
  function automatic logic [3:0] route(input logic [31:0] r,
                                       input logic [SRC-1:0] s);
    logic [3:0] o;
    logic [6:0] idx;
    for (int i = 0; i < 4; i++) begin
      idx = r[i*8 +: 7];
      o[i] = (idx < SRC) ? s[idx] : 1'b0;
    end
    return o;
  endfunction : route

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // outputs lag the select registers by one clock
  always @(negedge hclk) begin
    snap_b <= route(m_brk, srcs);
    snap_t <= route(m_trg, srcs);
  end

  always @(posedge hclk) begin
    #1;
    if (mon_on && hresetn) begin
      check({28'h0, brk}, {28'h0, snap_b});
      check({28'h0, trg}, {28'h0, snap_t});
    end
  end

  // ----------------------------------------------------------------------
  // bus and reset tasks
  // ----------------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] ad,
                      input logic [31:0] wd, output logic [31:0] rdo);
    hsel   <= 1'b1;
    haddr  <= ad;
    htrans <= trig_sel_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdo = hrdata;
    if (wr && ad == BRK && !m_brk[31]) m_brk = wd;
    if (wr && ad == TRG && !m_trg[31]) m_trg = wd;
  endtask : xfer

  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    xfer(1'b0, ad, 32'h0, rd);
    check(rd, exp);
    check({30'h0, hresp}, {30'h0, trig_sel_pkg::HRESP_OKAY});
    check({31'h0, hreadyout}, 32'h00000001);
  endtask : rchk

  task automatic do_reset();
    mon_on  <= 1'b0;
    hresetn <= 1'b0;
    m_brk = RB;
    m_trg = RT;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // outputs are still held low at the releasing edge
    @(posedge hclk);
    mon_on  <= 1'b1;
  endtask : do_reset

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    rchk(BRK, RB);
    rchk(TRG, RT);
    rchk(8'h30, 32'h0);
    repeat (24) begin
      a = ($random(seed) & 1) ? BRK : TRG;
      d = $random(seed) & 32'h7F7F7F7F;
      xfer(1'b1, a, d, rd);
      rchk(a, (a == BRK) ? m_brk : m_trg);
    end
    // boundary indices: last valid source and one past the list
    xfer(1'b1, BRK, 32'h63647F00, rd);
    repeat (6) @(posedge hclk);
    xfer(1'b1, BRK, 32'h80010203, rd);
    rchk(BRK, 32'h80010203);
    xfer(1'b1, BRK, 32'h00393939, rd);
    rchk(BRK, 32'h80010203);
    xfer(1'b1, TRG, 32'h04050607, rd);
    rchk(TRG, 32'h04050607);
    xfer(1'b1, TRG, 32'hFF7F7F7F, rd);
    xfer(1'b1, TRG, 32'h00000000, rd);
    rchk(TRG, 32'hFF7F7F7F);
    repeat (4) @(posedge hclk);
    do_reset();
    rchk(BRK, RB);
    rchk(TRG, RT);
    // lock gone after reset, so writes land again
    xfer(1'b1, BRK, 32'h01020304, rd);
    rchk(BRK, 32'h01020304);
    repeat (4) @(posedge hclk);
    wrap_up();
  end

  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
